// ===== icst_regs.svh
// register offsets, fields, reset values and timing counts for the internal clock settle/trim block
`ifndef ICST_REGS_SVH
`define ICST_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ICST_CTRL_OFF      12'h000
`define ICST_MULT_OFF      12'h004
`define ICST_TRIM_OFF      12'h008
`define ICST_DIV_OFF       12'h00C
`define ICST_STG_OFF       12'h010
`define ICST_STAT_OFF      12'h014
`define ICST_FTRIM_OFF     12'h018

// ----------------------------------------
// fields
// ----------------------------------------
`define ICST_CTRL_EN_BIT   0
`define ICST_CTRL_INTE_BIT 1
`define ICST_STAT_STB_BIT  0
`define ICST_STAT_LOCK_BIT 1
`define ICST_STAT_DONE_BIT 2
`define ICST_STAT_IRQ_BIT  3

// ----------------------------------------
// reset values and divider limit
// ----------------------------------------
`define ICST_MULT_RST      7'h15
`define ICST_TRIM_RST      8'h80
`define ICST_DIV_RST       4'h0
`define ICST_STG_RST       8'h80
`define ICST_DIV_MAX       4'h9

// ----------------------------------------
// capacitor and timing figures
// ----------------------------------------
`define ICST_CAP_FIXED     10'd384
`define ICST_CAP_TOTAL     10'd639
`define ICST_BASE_PER_CORR 4
`define ICST_FINE_MAX      24
`define ICST_TOTAL_MAX     32
`define ICST_BASE_HZ       307200
`define ICST_SYS_HZ        10000000
`define ICST_BASE_DIV      (`ICST_SYS_HZ / `ICST_BASE_HZ)
`define ICST_COARSE_TOL    16'd15
`define ICST_STABLE_TOL    16'd5

`endif

// ===== icst_pkg.sv
// types shared by the internal clock settle/trim block
package icst_pkg;
   typedef enum logic [1:0] {
      ICST_OFF,
      ICST_COARSE,
      ICST_FINE,
      ICST_LOCKED
   } icst_mode_e;
   typedef logic [7:0] icst_byte_t;
endpackage

// ===== icst_base_div.sv
// divider making the base-clock tick and the correction tick
`timescale 1ns/1ps
module icst_base_div #(
   parameter int DIV = 32,
   parameter int PER_CORR = 4
) (
   input  wire logic sys_clk_in,   // system clock
   input  wire logic rst_in,       // sync reset
   input  wire logic run_in,       // divider runs while high
   output logic      base_tick_out, // one pulse per base period
   output logic      corr_tick_out  // one pulse per correction
);
   logic [15:0] cnt_r, cnt_nxt;
   logic [2:0]  per_r, per_nxt;
   logic        bt_nxt, ct_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      per_nxt = per_r;
      bt_nxt  = 1'b0;
      ct_nxt  = 1'b0;
      if (run_in) begin
         if (cnt_r == 16'(DIV - 1)) begin
            cnt_nxt = '0;
            bt_nxt  = 1'b1;
            if (per_r == 3'(PER_CORR - 1)) begin
               per_nxt = '0;
               ct_nxt  = 1'b1;
            end else begin
               per_nxt = per_r + 3'd1;
            end
         end else begin
            cnt_nxt = cnt_r + 16'd1;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         cnt_r         <= '0;
         per_r         <= '0;
         base_tick_out <= 1'b0;
         corr_tick_out <= 1'b0;
      end else begin
         cnt_r         <= cnt_nxt;
         per_r         <= per_nxt;
         base_tick_out <= bt_nxt;
         corr_tick_out <= ct_nxt;
      end
   end
endmodule

// ===== icst_top.sv
// internal clock generator settling, preload and trim model with apb registers
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`include "icst_regs.svh"

// Operation
// - fine steps of one stage count, 24 at most
// - each correction spans four base periods
// - coarse plus fine capped at 32 corrections; here only corrections made within 15 percent are counted
// - divider and stage writable while generator off
// - restart from preloaded divider and stage
// - capacitor is 384 fixed plus trim units
// - trim resets to 128, capacitor 512
// - higher trim lowers base frequency
// - bus rate is base times multiplier over four; core enable here is base over four, multiplier unused
// - factory trim word reserved, read only
// - keeps running in wait, may wake cpu
// - stop halts activity, output clocks low
// - stop leaves all registers unchanged; here the core phase count clears and the wake request (status irq bit) drops
// - divider above nine acts as nine
// - stable flag cleared on multiplier write
module icst_top import icst_pkg::*; #(
   parameter logic [7:0] FACTORY_TRIM = 8'h80,  // arbitrary default factory value
   parameter int         BASE_DIV     = `ICST_BASE_DIV
) (
   input  wire logic        sys_clk_in,        // 10 MHz clock
   input  wire logic        rst_in,            // sync reset, active high
   input  wire logic        psel_in,           // apb select
   input  wire logic        penable_in,        // apb enable
   input  wire logic        pwrite_in,         // apb direction
   input  wire logic [11:0] paddr_in,          // apb byte address
   input  wire logic [31:0] pwdata_in,         // apb write data
   input  wire logic        stop_mode_in,      // stop mode request
   input  wire logic        wait_mode_in,      // wait mode indication
   input  wire logic [15:0] target_stage_in,   // stage count matching the target period
   output logic [31:0]      prdata_out,        // apb read data
   output logic             pready_out,        // apb ready
   output logic             pslverr_out,       // apb error on unmapped address
   output logic             internal_clock_stable_out, // stable within 5 percent
   output logic             osc_output_clock_out,      // oscillator clock enable
   output logic             core_output_clock_out,     // core clock enable
   output logic             wake_out,          // wake request from wait
   output logic [9:0]       cap_units_out      // connected capacitor units
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   logic        internal_gen_enable_r, internal_gen_enable_nxt;
   logic        inte_r, inte_nxt;
   logic [6:0]  mult_r, mult_nxt;
   icst_byte_t  trim_register_r, trim_register_nxt;
   logic [3:0]  dco_divider_exponent_r, dco_divider_exponent_nxt;
   icst_byte_t  dco_stage_setting_r, dco_stage_setting_nxt;
   icst_mode_e  mode_r, mode_nxt;
   logic [5:0]  corr_cnt_r, corr_cnt_nxt;
   logic [4:0]  fine_cnt_r, fine_cnt_nxt;
   logic        stable_r, stable_nxt;
   logic        wake_r, wake_nxt;
   logic [31:0] prdata_r, prdata_nxt;
   logic        pready_r, pready_nxt;
   logic        pslverr_r, pslverr_nxt;
   logic [2:0]  ph_r, ph_nxt;
   logic        osc_nxt;
   logic [9:0]  cap_r, cap_nxt;

   logic        base_tick, corr_tick;
   logic        run;
   logic        wr_acc, rd_acc;
   logic [3:0]  div_eff;
   logic [15:0] cur_period, err_abs, tol15, tol5;
   logic        too_slow;

   assign run    = internal_gen_enable_r & ~stop_mode_in;
   assign wr_acc = psel_in & penable_in & pwrite_in & ~pready_r;
   assign rd_acc = psel_in & penable_in & ~pwrite_in & ~pready_r;

   // ----------------------------------------
   // base clock and correction pacing
   // ----------------------------------------
   icst_base_div #(
      .DIV      (BASE_DIV),
      .PER_CORR (`ICST_BASE_PER_CORR)
   ) u_base (
      .sys_clk_in    (sys_clk_in),
      .rst_in        (rst_in),
      .run_in        (run),
      .base_tick_out (base_tick),
      .corr_tick_out (corr_tick)
   );

   // ----------------------------------------
   // dco period estimate and error
   // ----------------------------------------
   // period expressed as stage setting scaled by the clamped divider
   assign div_eff    = (dco_divider_exponent_r > `ICST_DIV_MAX) ? `ICST_DIV_MAX
                                                                 : dco_divider_exponent_r;
   assign cur_period = 16'(dco_stage_setting_r) << div_eff;
   assign too_slow   = cur_period > target_stage_in;
   assign err_abs    = too_slow ? (cur_period - target_stage_in) : (target_stage_in - cur_period);
   assign tol15      = 16'((32'(target_stage_in) * 32'(`ICST_COARSE_TOL)) / 32'd100);
   assign tol5       = 16'((32'(target_stage_in) * 32'(`ICST_STABLE_TOL)) / 32'd100);

   // ----------------------------------------
   // loop filter
   // ----------------------------------------
   always_comb begin
      mode_nxt                 = mode_r;
      corr_cnt_nxt             = corr_cnt_r;
      fine_cnt_nxt             = fine_cnt_r;
      stable_nxt               = stable_r;
      dco_divider_exponent_nxt = dco_divider_exponent_r;
      dco_stage_setting_nxt    = dco_stage_setting_r;
      if (!internal_gen_enable_r) begin
         mode_nxt     = ICST_OFF;
         stable_nxt   = 1'b0;
         corr_cnt_nxt = '0;
         fine_cnt_nxt = '0;
      end else if (!stop_mode_in && corr_tick) begin
         case (mode_r)
            ICST_OFF: begin
               // start from whatever divider and stage are held now
               mode_nxt = ICST_COARSE;
            end
            ICST_COARSE, ICST_FINE: begin
               if (err_abs <= tol5 && mode_r == ICST_COARSE) begin
                  mode_nxt   = ICST_FINE;
                  stable_nxt = 1'b1;
               end else if (err_abs == 16'd0 || fine_cnt_r == 5'(`ICST_FINE_MAX)
                            || corr_cnt_r == 6'(`ICST_TOTAL_MAX)) begin
                  mode_nxt = ICST_LOCKED;
               end else begin
                  if (err_abs <= tol5)
                     fine_cnt_nxt = fine_cnt_r + 5'd1;
                  if (err_abs <= tol15)
                     corr_cnt_nxt = corr_cnt_r + 6'd1;
                  // minimum step is one stage count; carry or borrow moves the divider
                  if (too_slow) begin
                     if (dco_stage_setting_r == 8'h00 && dco_divider_exponent_r != 4'h0) begin
                        dco_stage_setting_nxt    = 8'hFF;
                        dco_divider_exponent_nxt = dco_divider_exponent_r - 4'd1;
                     end else if (dco_stage_setting_r != 8'h00) begin
                        dco_stage_setting_nxt = dco_stage_setting_r - 8'd1;
                     end
                  end else begin
                     if (dco_stage_setting_r == 8'hFF && div_eff != `ICST_DIV_MAX) begin
                        dco_stage_setting_nxt    = 8'h00;
                        dco_divider_exponent_nxt = div_eff + 4'd1;
                     end else if (dco_stage_setting_r != 8'hFF) begin
                        dco_stage_setting_nxt = dco_stage_setting_r + 8'd1;
                     end
                  end
                  if (err_abs <= tol5)
                     stable_nxt = 1'b1;
               end
            end
            ICST_LOCKED: begin
               if (err_abs > tol5) begin
                  mode_nxt     = ICST_COARSE;
                  corr_cnt_nxt = '0;
                  fine_cnt_nxt = '0;
               end
            end
            default: mode_nxt = ICST_OFF;
         endcase
      end
      // software writes
      if (wr_acc && !internal_gen_enable_r) begin
         if (paddr_in == `ICST_DIV_OFF)
            dco_divider_exponent_nxt = pwdata_in[3:0];
         if (paddr_in == `ICST_STG_OFF)
            dco_stage_setting_nxt = pwdata_in[7:0];
      end
      if (wr_acc && (paddr_in == `ICST_MULT_OFF || paddr_in == `ICST_TRIM_OFF)
          && internal_gen_enable_r) begin
         stable_nxt   = 1'b0;
         mode_nxt     = ICST_COARSE;
         corr_cnt_nxt = '0;
         fine_cnt_nxt = '0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         mode_r                 <= ICST_OFF;
         corr_cnt_r             <= '0;
         fine_cnt_r             <= '0;
         stable_r               <= 1'b0;
         dco_divider_exponent_r <= `ICST_DIV_RST;
         dco_stage_setting_r    <= `ICST_STG_RST;
      end else begin
         mode_r                 <= mode_nxt;
         corr_cnt_r             <= corr_cnt_nxt;
         fine_cnt_r             <= fine_cnt_nxt;
         stable_r               <= stable_nxt;
         dco_divider_exponent_r <= dco_divider_exponent_nxt;
         dco_stage_setting_r    <= dco_stage_setting_nxt;
      end
   end

   // ----------------------------------------
   // apb registers
   // ----------------------------------------
   always_comb begin
      internal_gen_enable_nxt = internal_gen_enable_r;
      inte_nxt                = inte_r;
      mult_nxt                = mult_r;
      trim_register_nxt       = trim_register_r;
      prdata_nxt              = prdata_r;
      pready_nxt              = 1'b0;
      pslverr_nxt             = 1'b0;
      if (psel_in && penable_in && !pready_r) begin
         pready_nxt = 1'b1;
         prdata_nxt = '0;
         case (paddr_in)
            `ICST_CTRL_OFF: begin
               prdata_nxt[`ICST_CTRL_EN_BIT]   = internal_gen_enable_r;
               prdata_nxt[`ICST_CTRL_INTE_BIT] = inte_r;
               if (pwrite_in) begin
                  internal_gen_enable_nxt = pwdata_in[`ICST_CTRL_EN_BIT];
                  inte_nxt                = pwdata_in[`ICST_CTRL_INTE_BIT];
               end
            end
            `ICST_MULT_OFF: begin
               prdata_nxt[6:0] = mult_r;
               if (pwrite_in)
                  mult_nxt = pwdata_in[6:0];
            end
            `ICST_TRIM_OFF: begin
               prdata_nxt[7:0] = trim_register_r;
               if (pwrite_in)
                  trim_register_nxt = pwdata_in[7:0];
            end
            `ICST_DIV_OFF: prdata_nxt[3:0] = dco_divider_exponent_r;
            `ICST_STG_OFF: prdata_nxt[7:0] = dco_stage_setting_r;
            `ICST_STAT_OFF: begin
               prdata_nxt[`ICST_STAT_STB_BIT]  = stable_r;
               prdata_nxt[`ICST_STAT_LOCK_BIT] = (mode_r == ICST_LOCKED);
               prdata_nxt[`ICST_STAT_DONE_BIT] = (mode_r == ICST_FINE);
               prdata_nxt[`ICST_STAT_IRQ_BIT]  = wake_r;
            end
            `ICST_FTRIM_OFF: prdata_nxt[7:0] = FACTORY_TRIM;
            default: pslverr_nxt = 1'b1;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         internal_gen_enable_r <= 1'b1;
         inte_r                <= 1'b0;
         mult_r                <= `ICST_MULT_RST;
         trim_register_r       <= `ICST_TRIM_RST;
         prdata_r              <= '0;
         pready_r              <= 1'b0;
         pslverr_r             <= 1'b0;
      end else begin
         // stop mode has no path into these registers
         internal_gen_enable_r <= internal_gen_enable_nxt;
         inte_r                <= inte_nxt;
         mult_r                <= mult_nxt;
         trim_register_r       <= trim_register_nxt;
         prdata_r              <= prdata_nxt;
         pready_r              <= pready_nxt;
         pslverr_r             <= pslverr_nxt;
      end
   end

   // ----------------------------------------
   // output clocks, capacitor, wake
   // ----------------------------------------
   // clock enables pulse per base tick and every fourth base tick; held low in stop
   always_comb begin
      ph_nxt   = ph_r;
      osc_nxt  = 1'b0;
      wake_nxt = 1'b0;
      cap_nxt  = `ICST_CAP_FIXED + 10'(trim_register_r);
      if (run) begin
         osc_nxt  = base_tick;
         ph_nxt   = base_tick ? ph_r + 3'd1 : ph_r;
         wake_nxt = inte_r & wait_mode_in & stable_r;
      end else if (stop_mode_in) begin
         ph_nxt = '0;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         ph_r  <= '0;
         wake_r <= 1'b0;
         cap_r <= `ICST_CAP_FIXED + 10'(`ICST_TRIM_RST);
         internal_clock_stable_out <= 1'b0;
         osc_output_clock_out      <= 1'b0;
         core_output_clock_out     <= 1'b0;
      end else begin
         ph_r  <= ph_nxt;
         wake_r <= wake_nxt;
         cap_r <= cap_nxt;
         internal_clock_stable_out <= stable_nxt;
         osc_output_clock_out      <= osc_nxt;
         // core enable at one quarter of the oscillator rate
         core_output_clock_out     <= osc_nxt & (ph_r[1:0] == 2'b11);
      end
   end

   assign prdata_out    = prdata_r;
   assign pready_out    = pready_r;
   assign pslverr_out   = pslverr_r;
   assign wake_out      = wake_r;
   assign cap_units_out = cap_r;
endmodule

// ===== icst_chk.sv
// assertion checker for the internal clock settle/trim block
`timescale 1ns/1ps
`include "icst_regs.svh"
module icst_chk (
   input wire logic        sys_clk_in,                // clock
   input wire logic        rst_in,                    // sync reset
   input wire logic        psel_in,                   // apb select
   input wire logic        penable_in,                // apb enable
   input wire logic        pwrite_in,                 // apb direction
   input wire logic [11:0] paddr_in,                  // apb address
   input wire logic [31:0] pwdata_in,                 // apb write data
   input wire logic        stop_mode_in,              // stop mode
   input wire logic        wait_mode_in,              // wait mode
   input wire logic [15:0] target_stage_in,           // target period
   input wire logic [31:0] prdata_out,                // read data
   input wire logic        pready_out,                // ready
   input wire logic        pslverr_out,               // error
   input wire logic        internal_clock_stable_out, // stable flag
   input wire logic        osc_output_clock_out,      // osc clock
   input wire logic        core_output_clock_out,     // core clock
   input wire logic        wake_out,                  // wake request
   input wire logic [9:0]  cap_units_out              // capacitor units
);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   chk_cap_range: assert property (cap_units_out >= 10'h180 && cap_units_out <= 10'h27F)
      else $error("capacitor units out of range");
   // one edge of grace: the outputs are registered behind the stop input
   chk_stop_low: assert property (stop_mode_in && $past(stop_mode_in) |->
      !osc_output_clock_out && !core_output_clock_out)
      else $error("clock pulse during stop");
   chk_stop_hold: assert property (stop_mode_in && $past(stop_mode_in) && !$past(psel_in) |->
      $stable(cap_units_out))
      else $error("capacitor setting moved during stop");
   chk_apb_answer: assert property (psel_in && penable_in && !pready_out |=> pready_out)
      else $error("no ready one cycle after access");
   chk_ready_pulse: assert property (pready_out |=> !pready_out)
      else $error("ready longer than one cycle");
   chk_wake_cond: assert property (wake_out |-> (wait_mode_in || $past(wait_mode_in)) &&
      (internal_clock_stable_out || $past(internal_clock_stable_out)))
      else $error("wake without wait and stable");
   chk_mult_clear: assert property (psel_in && penable_in && pwrite_in && !pready_out &&
      paddr_in == `ICST_MULT_OFF |-> ##[1:3] !internal_clock_stable_out)
      else $error("stable flag kept after multiplier write");
   chk_osc_pulse: assert property (osc_output_clock_out |=> !osc_output_clock_out)
      else $error("oscillator pulse wider than one cycle");
   chk_core_gap: assert property (core_output_clock_out |=> !core_output_clock_out [*3])
      else $error("core pulses too close");
endmodule

bind icst_top icst_chk icst_chk_i (
   .sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
   .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .stop_mode_in(stop_mode_in),
   .wait_mode_in(wait_mode_in), .target_stage_in(target_stage_in), .prdata_out(prdata_out),
   .pready_out(pready_out), .pslverr_out(pslverr_out), .internal_clock_stable_out(internal_clock_stable_out),
   .osc_output_clock_out(osc_output_clock_out), .core_output_clock_out(core_output_clock_out),
   .wake_out(wake_out), .cap_units_out(cap_units_out));

// ===== test_internal_clock_settle_trim.sv
// self-checking bench for the internal clock settle/trim block
`timescale 1ns/1ps
`include "icst_regs.svh"
module test_internal_clock_settle_trim;
   typedef struct {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] v; logic e;} icst_row_s;
   logic        sys_clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic        psel_in = 1'b0;
   logic        penable_in = 1'b0;
   logic        pwrite_in = 1'b0;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0000_0000;
   logic        stop_mode_in = 1'b0;
   logic        wait_mode_in = 1'b0;
   logic [15:0] target_stage_in = 16'h0080;
   logic [31:0] prdata_out;
   logic        pready_out;
   logic        pslverr_out;
   logic        internal_clock_stable_out;
   logic        osc_output_clock_out;
   logic        core_output_clock_out;
   logic        wake_out;
   logic [9:0]  cap_units_out;
   logic [31:0] rd;
   logic        err;
   int          n_mismatch = 0;
   int          checks_done = 0;
   int          n_osc;
   int          n_core;
   logic [7:0]  trims [3] = '{8'h00, 8'hFF, 8'h80};
   logic [9:0]  caps [3] = '{10'h180, 10'h27F, 10'h200};
   // reset reads, then ignored writes read back; unmapped places answer with an error
   icst_row_s   rows [11] = '{
      '{1'b0, `ICST_CTRL_OFF, 8'h00, 8'h01, 1'b0}, '{1'b0, `ICST_MULT_OFF, 8'h00, 8'h15, 1'b0},
      '{1'b0, `ICST_TRIM_OFF, 8'h00, 8'h80, 1'b0}, '{1'b0, `ICST_DIV_OFF, 8'h00, 8'h00, 1'b0},
      '{1'b0, `ICST_STG_OFF, 8'h00, 8'h80, 1'b0}, '{1'b0, `ICST_FTRIM_OFF, 8'h00, 8'h5A, 1'b0},
      '{1'b0, 12'h01C, 8'h00, 8'h00, 1'b1}, '{1'b1, `ICST_FTRIM_OFF, 8'hFF, 8'h5A, 1'b0},
      '{1'b1, `ICST_DIV_OFF, 8'h05, 8'h00, 1'b0}, '{1'b1, `ICST_STG_OFF, 8'h40, 8'h80, 1'b0},
      '{1'b1, 12'h7FC, 8'h55, 8'h00, 1'b1}};

   always #50 sys_clk_in = ~sys_clk_in;

   icst_top #(
      .FACTORY_TRIM(8'h5A), // arbitrary value
      .BASE_DIV(2)          // short base period keeps the run brief
   ) icst_top_i (
      .sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
      .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .stop_mode_in(stop_mode_in),
      .wait_mode_in(wait_mode_in), .target_stage_in(target_stage_in), .prdata_out(prdata_out),
      .pready_out(pready_out), .pslverr_out(pslverr_out), .internal_clock_stable_out(internal_clock_stable_out),
      .osc_output_clock_out(osc_output_clock_out), .core_output_clock_out(core_output_clock_out),
      .wake_out(wake_out), .cap_units_out(cap_units_out));

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic miss(input string what);
      n_mismatch++;
      $display("unexpected at %0t: %s", $time, what);
   endtask
   task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) miss($sformatf("%s got %h expected %h", what, got, exp));
   endtask
   task automatic cmp_flag(input logic got, input logic exp, input string what);
      checks_done++;
      if (got !== exp) miss(what);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_in);
   endtask
   // request held from setup until ready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge sys_clk_in);
      psel_in <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in <= wr;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge sys_clk_in);
      penable_in <= 1'b1;
      do begin
         @(posedge sys_clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 16);
      if (pready_out !== 1'b1) begin
         miss("bus answer timed out");
         tally_and_finish();
      end else begin
         rd = prdata_out;
         err = pslverr_out;
         psel_in <= 1'b0;
         penable_in <= 1'b0;
      end
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      cmp_word(rd, exp, "register read");
   endtask
   task automatic pulses(input int n);
      n_osc = 0;
      n_core = 0;
      repeat (n) begin
         @(posedge sys_clk_in);
         n_osc += int'(osc_output_clock_out === 1'b1);
         n_core += int'(core_output_clock_out === 1'b1);
      end
   endtask

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      tick(8);
      rst_in <= 1'b0;
      cmp_word({22'h00_0000, cap_units_out}, 32'h0000_0200, "capacitor at reset");
      foreach (rows[i]) begin
         if (rows[i].w) apb(1'b1, rows[i].a, {24'h00_0000, rows[i].d});
         apb(1'b0, rows[i].a, 32'h0000_0000);
         cmp_word(rd, {24'h00_0000, rows[i].v}, "row read");
         cmp_flag(err, rows[i].e, "error response");
      end
      foreach (trims[i]) begin
         apb(1'b1, `ICST_TRIM_OFF, {24'h00_0000, trims[i]});
         tick(2);
         cmp_word({22'h00_0000, cap_units_out}, {22'h00_0000, caps[i]}, "capacitor units");
      end
      rdchk(`ICST_TRIM_OFF, 32'h0000_0080);
      $display("test table done");
      // preload while off, restart from the written point
      apb(1'b1, `ICST_CTRL_OFF, 32'h0000_0000);
      apb(1'b1, `ICST_DIV_OFF, 32'h0000_0003);
      apb(1'b1, `ICST_STG_OFF, 32'h0000_0040);
      rdchk(`ICST_DIV_OFF, 32'h0000_0003);
      rdchk(`ICST_STG_OFF, 32'h0000_0040);
      target_stage_in <= 16'h0200;
      apb(1'b1, `ICST_CTRL_OFF, 32'h0000_0001);
      tick(40);
      rdchk(`ICST_DIV_OFF, 32'h0000_0003);
      rdchk(`ICST_STG_OFF, 32'h0000_0040);
      $display("test preload done");
      // ten stage counts away: settle and lock within the correction budget
      target_stage_in <= 16'h0250;
      apb(1'b1, `ICST_MULT_OFF, 32'h0000_0015);
      cmp_flag(internal_clock_stable_out, 1'b0, "stable after multiplier write");
      pulses(256);
      cmp_flag(internal_clock_stable_out, 1'b1, "stable within budget");
      tick(300);
      rdchk(`ICST_STG_OFF, 32'h0000_004A);
      apb(1'b0, `ICST_STAT_OFF, 32'h0000_0000);
      cmp_flag(rd[`ICST_STAT_LOCK_BIT], 1'b1, "locked flag");
      $display("test settle done");
      apb(1'b1, `ICST_CTRL_OFF, 32'h0000_0003);
      wait_mode_in <= 1'b1;
      tick(3);
      cmp_flag(wake_out, 1'b1, "wake in wait");
      pulses(64);
      cmp_word(32'(n_osc), 32'h0000_0020, "osc pulses in wait");
      cmp_word(32'(n_core), 32'h0000_0008, "core pulses in wait");
      wait_mode_in <= 1'b0;
      tick(3);
      cmp_flag(wake_out, 1'b0, "wake after wait");
      $display("test wait done");
      stop_mode_in <= 1'b1;
      tick(2);
      pulses(40);
      cmp_word(32'(n_osc + n_core), 32'h0000_0000, "pulses in stop");
      cmp_word({22'h00_0000, cap_units_out}, 32'h0000_0200, "capacitor in stop");
      stop_mode_in <= 1'b0;
      rdchk(`ICST_STG_OFF, 32'h0000_004A);
      rdchk(`ICST_DIV_OFF, 32'h0000_0003);
      rdchk(`ICST_CTRL_OFF, 32'h0000_0003);
      $display("test stop done");
      // divider twelve behaves as nine, so this target has no error
      apb(1'b1, `ICST_CTRL_OFF, 32'h0000_0000);
      apb(1'b1, `ICST_DIV_OFF, 32'h0000_000C);
      apb(1'b1, `ICST_STG_OFF, 32'h0000_0040);
      target_stage_in <= 16'h8000;
      apb(1'b1, `ICST_CTRL_OFF, 32'h0000_0001);
      tick(200);
      rdchk(`ICST_STG_OFF, 32'h0000_0040);
      $display("test divider limit done");
      // stage 0x100 at exponent 7 is over 255: software halves it, exponent 8
      apb(1'b1, `ICST_CTRL_OFF, 32'h0000_0000);
      apb(1'b1, `ICST_DIV_OFF, 32'h0000_0008);
      apb(1'b1, `ICST_STG_OFF, 32'h0000_0080);
      apb(1'b1, `ICST_CTRL_OFF, 32'h0000_0001);
      tick(100);
      rdchk(`ICST_STG_OFF, 32'h0000_0080);
      // half the period: stage kept, exponent down by one
      apb(1'b1, `ICST_CTRL_OFF, 32'h0000_0000);
      target_stage_in <= 16'h4000;
      apb(1'b1, `ICST_DIV_OFF, 32'h0000_0007);
      apb(1'b1, `ICST_CTRL_OFF, 32'h0000_0001);
      tick(100);
      rdchk(`ICST_STG_OFF, 32'h0000_0080);
      rdchk(`ICST_DIV_OFF, 32'h0000_0007);
      $display("test software steps done");
      tally_and_finish();
   end
endmodule
